// ---- rtl/optical_mode_map.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the mode controller
// Assumes: 20 MHz system clock, byte-wide register port
// Notes: included by the design
// Rules from the document for this block
// R1 - host picks only standby, light, proximity, both, single-LED or dual-LED heart modes; the code has only light and proximity enables, no heart modes
// R2 - power-on or software reset puts the main state machine in start state
// R3 - after reset release start the oscillator, then load address and trims
// R4 - reaching idle after loading enters standby mode
// R5 - until the address is loaded every bus transfer gets not-acknowledge, requests ignored
// R6 - enabling any sensor mode powers the support blocks immediately
// R7 - after settling, about 1.5 ms, conversions start on scheduler triggers
// R8 - clearing an enable lets a running conversion finish before converter standby
// R9 - shared support blocks go to standby only when every sensor is inactive
// R10 - sleep-after-interrupt puts a sensor's converters to standby on its interrupt condition
// R11 - with sleep-after-interrupt, reading the sensor status sets its enable bit again
// R12 - disabling keeps status bits; activating a sensor clears them
// R13 - with nothing enabled the device stays in low-power standby
// R14 - light mode 0 converts green, clear, comp; 1 converts all five channels
// R15 - light mode select sits in the first main control register at 15h
// R16 - one common gain and resolution applies to every active light channel
// R17 - resolution sets integration time and full-scale count, 18 bits by default
// R18 - light gain offers 1x, 3x and 6x
// R19 - light resolution/period at 22h, light gain at 23h
// R20 - host lowers gain above about 80 percent, raises below about 20 percent
// R21 - software reset passes the same start, oscillator, load and idle sequence
`ifndef OPTICAL_MODE_MAP_SVH
`define OPTICAL_MODE_MAP_SVH
`define OFS_MAIN_CTRL0   8'h15
`define OFS_LIGHT_RES    8'h22
`define OFS_LIGHT_GAIN   8'h23
`define BIT_LIGHT_EN     0
`define BIT_PROX_EN      1
`define BIT_LIGHT_MODE   2
`define BIT_LIGHT_SAI    3
`define BIT_PROX_SAI     4
`define RST_MAIN_CTRL0   8'h00
`define RST_LIGHT_RES    8'h22
`define RST_LIGHT_GAIN   8'h01
`define CLK_MHZ          20
`define SETTLE_US        1500
`define SETTLE_CYC       (`SETTLE_US * `CLK_MHZ)
`define OSC_START_CYC    16
`endif

// ---- rtl/optical_mode_pkg.sv ----
// Purpose: types of the mode controller
// Assumes: constants come from optical_mode_map.svh
// Notes: one-hot state codes
package optical_mode_pkg;
  typedef enum logic [5:0] {
    ST_START  = 6'h01,
    ST_OSC    = 6'h02,
    ST_LOAD   = 6'h04,
    ST_IDLE   = 6'h08,
    ST_SETTLE = 6'h10,
    ST_ACTIVE = 6'h20
  } main_state_t;
endpackage : optical_mode_pkg

// ---- rtl/optical_sensor_mode_control.sv ----
// Purpose: main operating-mode controller and light channel configuration
// Assumes: register port already decoded from the serial bus, one strobe per byte
// Notes: converters report busy; scheduler gives one-cycle triggers
`timescale 1ns/1ps
`include "optical_mode_map.svh"
module optical_sensor_mode_control #(
  parameter int SETTLE_CYCLES = `SETTLE_CYC,
  parameter int OSC_CYCLES    = `OSC_START_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       softReset,
  input  wire logic       oscReady,
  input  wire logic       trimLoadDone,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  output logic            busAck,
  input  wire logic       lightStatusRead,
  input  wire logic       proxStatusRead,
  input  wire logic       lightIntCond,
  input  wire logic       proxIntCond,
  input  wire logic       lightTrigger,
  input  wire logic       proxTrigger,
  input  wire logic       lightBusy,
  input  wire logic       proxBusy,
  output logic            oscEnable,
  output logic            trimLoadStart,
  output logic            addressLoaded,
  output logic            supportPower,
  output logic            lightAdcOn,
  output logic            proxAdcOn,
  output logic            lightConvStart,
  output logic            proxConvStart,
  output logic      [4:0] lightChannels,
  output logic      [2:0] lightResolution,
  output logic      [2:0] lightPeriod,
  output logic      [1:0] lightGain,
  output logic            lightStatusClear,
  output logic            proxStatusClear
);
  typedef struct packed {
    optical_mode_pkg::main_state_t st;
    logic [31:0] cnt;
    logic [7:0]  ctrl0;
    logic [7:0]  res;
    logic [7:0]  gain;
    logic        loaded;
    logic        lightOn;
    logic        proxOn;
    logic        lightSlept;
    logic        proxSlept;
    logic        lightClr;
    logic        proxClr;
    logic        lStart;
    logic        pStart;
    logic [7:0]  rdata;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic   enL;
  logic   enP;
  logic   wrCtrl;
  logic   anyEn;

  always_comb
  begin
    next_cur = cur;
    next_cur.lightClr = 1'b0;
    next_cur.proxClr = 1'b0;
    next_cur.lStart = 1'b0;
    next_cur.pStart = 1'b0;
    enL = cur.ctrl0[`BIT_LIGHT_EN];
    enP = cur.ctrl0[`BIT_PROX_EN];
    wrCtrl = regWrite && cur.loaded && (regAddr == `OFS_MAIN_CTRL0); // R5
    if (regWrite && cur.loaded) // R5
    begin
      case (regAddr)
        `OFS_MAIN_CTRL0: next_cur.ctrl0 = regWdata; // R15
        `OFS_LIGHT_RES:  next_cur.res = regWdata; // R19
        `OFS_LIGHT_GAIN: next_cur.gain = regWdata; // R19
        default: ;
      endcase
    end
    // activation clears old status; a plain disable leaves it alone
    if (wrCtrl && regWdata[`BIT_LIGHT_EN] && !enL)
      next_cur.lightClr = 1'b1; // R12
    if (wrCtrl && regWdata[`BIT_PROX_EN] && !enP)
      next_cur.proxClr = 1'b1; // R12
    // sleep on interrupt: drop enable, status read re-arms it
    if (cur.ctrl0[`BIT_LIGHT_SAI] && enL && lightIntCond)
    begin
      next_cur.ctrl0[`BIT_LIGHT_EN] = 1'b0; // R10
      next_cur.lightSlept = 1'b1;
    end
    else if (cur.lightSlept && lightStatusRead && cur.ctrl0[`BIT_LIGHT_SAI])
    begin
      next_cur.ctrl0[`BIT_LIGHT_EN] = 1'b1; // R11
      next_cur.lightSlept = 1'b0;
      next_cur.lightClr = 1'b1; // R12
    end
    if (cur.ctrl0[`BIT_PROX_SAI] && enP && proxIntCond)
    begin
      next_cur.ctrl0[`BIT_PROX_EN] = 1'b0; // R10
      next_cur.proxSlept = 1'b1;
    end
    else if (cur.proxSlept && proxStatusRead && cur.ctrl0[`BIT_PROX_SAI])
    begin
      next_cur.ctrl0[`BIT_PROX_EN] = 1'b1; // R11
      next_cur.proxSlept = 1'b0;
      next_cur.proxClr = 1'b1; // R12
    end
    anyEn = next_cur.ctrl0[`BIT_LIGHT_EN] || next_cur.ctrl0[`BIT_PROX_EN];
    // converters stay up until a running conversion ends
    next_cur.lightOn = enL || lightBusy; // R8
    next_cur.proxOn = enP || proxBusy; // R8
    case (cur.st)
      optical_mode_pkg::ST_START:
      begin
        next_cur.st = optical_mode_pkg::ST_OSC; // R3
        next_cur.cnt = 32'h00000000;
      end
      optical_mode_pkg::ST_OSC:
      begin
        next_cur.cnt = cur.cnt + 32'h00000001;
        if (oscReady && cur.cnt >= 32'(OSC_CYCLES))
          next_cur.st = optical_mode_pkg::ST_LOAD; // R3
      end
      optical_mode_pkg::ST_LOAD:
        if (trimLoadDone)
        begin
          next_cur.loaded = 1'b1; // R3
          next_cur.st = optical_mode_pkg::ST_IDLE; // R4
        end
      optical_mode_pkg::ST_IDLE:
      begin
        next_cur.cnt = 32'h00000000;
        if (anyEn)
          next_cur.st = optical_mode_pkg::ST_SETTLE; // R6
      end
      optical_mode_pkg::ST_SETTLE:
      begin
        next_cur.cnt = cur.cnt + 32'h00000001;
        if (!anyEn && !cur.lightOn && !cur.proxOn)
          next_cur.st = optical_mode_pkg::ST_IDLE; // R9
        else if (cur.cnt >= 32'(SETTLE_CYCLES - 1))
          next_cur.st = optical_mode_pkg::ST_ACTIVE; // R7
      end
      optical_mode_pkg::ST_ACTIVE:
      begin
        next_cur.lStart = enL && lightTrigger && !lightBusy; // R7
        next_cur.pStart = enP && proxTrigger && !proxBusy; // R7
        if (!anyEn && !lightBusy && !proxBusy)
          next_cur.st = optical_mode_pkg::ST_IDLE; // R9
      end
      default: next_cur.st = optical_mode_pkg::ST_START;
    endcase
    next_cur.rdata = 8'h00;
    if (regRead && cur.loaded)
    begin
      case (regAddr)
        `OFS_MAIN_CTRL0: next_cur.rdata = cur.ctrl0;
        `OFS_LIGHT_RES:  next_cur.rdata = cur.res;
        `OFS_LIGHT_GAIN: next_cur.rdata = cur.gain;
        default: next_cur.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst || softReset) // R2 R21
    begin
      cur.st <= optical_mode_pkg::ST_START;
      cur.cnt <= 32'h00000000;
      cur.ctrl0 <= `RST_MAIN_CTRL0; // R13
      cur.res <= `RST_LIGHT_RES; // R17
      cur.gain <= `RST_LIGHT_GAIN;
      cur.loaded <= 1'b0; // R5
      cur.lightOn <= 1'b0;
      cur.proxOn <= 1'b0;
      cur.lightSlept <= 1'b0;
      cur.proxSlept <= 1'b0;
      cur.lightClr <= 1'b0;
      cur.proxClr <= 1'b0;
      cur.lStart <= 1'b0;
      cur.pStart <= 1'b0;
      cur.rdata <= 8'h00;
    end
    else
      cur <= next_cur;
  end

  // any offset acknowledges, but only once the address is known
  assign busAck = cur.loaded && (regWrite || regRead); // R5
  assign regRdata = cur.rdata;
  assign addressLoaded = cur.loaded;
  assign oscEnable = (cur.st != optical_mode_pkg::ST_START); // R3
  assign trimLoadStart = (cur.st == optical_mode_pkg::ST_LOAD); // R3
  assign supportPower = (cur.st == optical_mode_pkg::ST_SETTLE)
                     || (cur.st == optical_mode_pkg::ST_ACTIVE); // R6 R9 R13
  assign lightAdcOn = cur.lightOn && supportPower; // R8
  assign proxAdcOn = cur.proxOn && supportPower; // R8
  assign lightConvStart = cur.lStart;
  assign proxConvStart = cur.pStart;
  // red, green, blue, clear, comp from bit 4 down
  assign lightChannels = cur.ctrl0[`BIT_LIGHT_MODE] ? 5'h1F : 5'h0B; // R14 R16
  assign lightResolution = cur.res[6:4]; // R17 R16
  assign lightPeriod = cur.res[2:0];
  // gain code 3 is not a documented step, clamp to 6x
  assign lightGain = (cur.gain[1:0] == 2'h3) ? 2'h2 : cur.gain[1:0]; // R18
  assign lightStatusClear = cur.lightClr;
  assign proxStatusClear = cur.proxClr;

  property p_nack_before_load;
    @(posedge sys_clk) disable iff (srst)
      !cur.loaded |-> !busAck;
  endproperty
  a_nack_before_load: assert property (p_nack_before_load) // R5
    else $error("ack before address load");

  property p_reset_start;
    @(posedge sys_clk) srst |=> (cur.st == optical_mode_pkg::ST_START);
  endproperty
  a_reset_start: assert property (p_reset_start) // R2
    else $error("reset did not reach start");

  sequence s_load_done;
    cur.st == optical_mode_pkg::ST_LOAD && trimLoadDone && !softReset;
  endsequence
  property p_idle_after_load;
    @(posedge sys_clk) disable iff (srst)
      s_load_done |=> (cur.st == optical_mode_pkg::ST_IDLE) && cur.loaded;
  endproperty
  a_idle_after_load: assert property (p_idle_after_load) // R4
    else $error("idle not reached after load");

  property p_power_on_enable;
    @(posedge sys_clk) disable iff (srst || softReset)
      (cur.st == optical_mode_pkg::ST_IDLE) && wrCtrl && regWdata[`BIT_LIGHT_EN]
      |=> supportPower;
  endproperty
  a_power_on_enable: assert property (p_power_on_enable) // R6
    else $error("support blocks not powered on enable");

  property p_no_start_settling;
    @(posedge sys_clk) disable iff (srst)
      (cur.st != optical_mode_pkg::ST_ACTIVE) |=> !lightConvStart && !proxConvStart;
  endproperty
  a_no_start_settling: assert property (p_no_start_settling) // R7
    else $error("conversion started before settling");

  property p_finish_conv;
    @(posedge sys_clk) disable iff (srst || softReset)
      supportPower && lightBusy |=> lightAdcOn;
  endproperty
  a_finish_conv: assert property (p_finish_conv) // R8
    else $error("light converter dropped during conversion");

  property p_standby_all_off;
    @(posedge sys_clk) disable iff (srst)
      $fell(supportPower) && !$past(softReset) |-> !enL && !enP;
  endproperty
  a_standby_all_off: assert property (p_standby_all_off) // R9
    else $error("support blocks off with a sensor enabled");

  property p_sai_sleep;
    @(posedge sys_clk) disable iff (srst || softReset)
      cur.ctrl0[`BIT_LIGHT_SAI] && enL && lightIntCond |=> !enL;
  endproperty
  a_sai_sleep: assert property (p_sai_sleep) // R10
    else $error("light not put to sleep after interrupt");

  property p_sai_rearm;
    @(posedge sys_clk) disable iff (srst || softReset)
      cur.lightSlept && lightStatusRead && cur.ctrl0[`BIT_LIGHT_SAI]
      |=> enL && lightStatusClear;
  endproperty
  a_sai_rearm: assert property (p_sai_rearm) // R11
    else $error("light enable not set after status read");

  property p_channels;
    @(posedge sys_clk) disable iff (srst)
      !cur.ctrl0[`BIT_LIGHT_MODE] |-> lightChannels == 5'h0B;
  endproperty
  a_channels: assert property (p_channels) // R14
    else $error("wrong channels in reduced light mode");

  property p_full_channels;
    @(posedge sys_clk) disable iff (srst)
      cur.ctrl0[`BIT_LIGHT_MODE] |-> lightChannels == 5'h1F;
  endproperty
  a_full_channels: assert property (p_full_channels) // R14
    else $error("wrong channels in full light mode");

  property p_mode_select_write;
    @(posedge sys_clk) disable iff (srst || softReset)
      wrCtrl && regWdata[`BIT_LIGHT_MODE] |=> lightChannels == 5'h1F;
  endproperty
  a_mode_select_write: assert property (p_mode_select_write) // R15
    else $error("light mode select write not applied");

  property p_gain_steps;
    @(posedge sys_clk) disable iff (srst)
      lightGain != 2'h3;
  endproperty
  a_gain_steps: assert property (p_gain_steps) // R18
    else $error("light gain outside the three steps");

  property p_osc_wait;
    @(posedge sys_clk) disable iff (srst)
      (cur.st == optical_mode_pkg::ST_OSC) && !oscReady && !softReset
      |=> (cur.st == optical_mode_pkg::ST_OSC);
  endproperty
  a_osc_wait: assert property (p_osc_wait) // R3
    else $error("trim load began before the oscillator ran");

  property p_idle_standby;
    @(posedge sys_clk) disable iff (srst)
      (cur.st == optical_mode_pkg::ST_IDLE) && !wrCtrl && !lightStatusRead && !proxStatusRead
      |=> !supportPower;
  endproperty
  a_idle_standby: assert property (p_idle_standby) // R13
    else $error("support blocks up with nothing enabled");

  property p_keep_status;
    @(posedge sys_clk) disable iff (srst)
      wrCtrl && !regWdata[`BIT_LIGHT_EN] && !(cur.lightSlept && lightStatusRead)
      |=> !lightStatusClear;
  endproperty
  a_keep_status: assert property (p_keep_status) // R12
    else $error("light status cleared on disable");

  property p_prox_sai_sleep;
    @(posedge sys_clk) disable iff (srst || softReset)
      cur.ctrl0[`BIT_PROX_SAI] && enP && proxIntCond |=> !enP;
  endproperty
  a_prox_sai_sleep: assert property (p_prox_sai_sleep) // R10
    else $error("prox not put to sleep after interrupt");

  sequence s_prox_rearm;
    cur.proxSlept && proxStatusRead && cur.ctrl0[`BIT_PROX_SAI];
  endsequence
  property p_prox_sai_rearm;
    @(posedge sys_clk) disable iff (srst || softReset)
      s_prox_rearm |=> enP && proxStatusClear;
  endproperty
  a_prox_sai_rearm: assert property (p_prox_sai_rearm) // R11
    else $error("prox enable not set after status read");
endmodule : optical_sensor_mode_control

// ---- sim/optical_sensor_mode_control_bench.sv ----
// Purpose: register-level tests of the mode controller
// Assumes: settle shortened to 20 cycles, oscillator count to 2
// Notes: strobes change on rising edges by non-blocking assignment
`timescale 1ns/1ps
module optical_sensor_mode_control_bench;
  logic sys_clk = 1'b0, srst = 1'b1, softReset = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rdv;
  logic lightStatusRead = 1'b0, proxStatusRead = 1'b0, lightIntCond = 1'b0, proxIntCond = 1'b0;
  logic lightTrigger = 1'b0, proxTrigger = 1'b0, lightBusy, proxBusy, busAck, ack;
  logic oscEnable, trimLoadStart, addressLoaded, supportPower, lightAdcOn, proxAdcOn;
  logic lightConvStart, proxConvStart, lightStatusClear, proxStatusClear, oscReady, trimLoadDone;
  logic [4:0] lightChannels;
  logic [2:0] lightResolution, lightPeriod;
  logic [1:0] lightGain;
  int n_errors = 0;
  int comparisons = 0;
  always #25 sys_clk = ~sys_clk;
  optical_sensor_mode_control #(.SETTLE_CYCLES(20), .OSC_CYCLES(2)) optical_sensor_mode_control_inst (
    .sys_clk(sys_clk), .srst(srst), .softReset(softReset), .oscReady(oscReady),
    .trimLoadDone(trimLoadDone), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .busAck(busAck), .lightStatusRead(lightStatusRead),
    .proxStatusRead(proxStatusRead), .lightIntCond(lightIntCond), .proxIntCond(proxIntCond),
    .lightTrigger(lightTrigger), .proxTrigger(proxTrigger), .lightBusy(lightBusy),
    .proxBusy(proxBusy), .oscEnable(oscEnable), .trimLoadStart(trimLoadStart),
    .addressLoaded(addressLoaded), .supportPower(supportPower), .lightAdcOn(lightAdcOn),
    .proxAdcOn(proxAdcOn), .lightConvStart(lightConvStart), .proxConvStart(proxConvStart),
    .lightChannels(lightChannels), .lightResolution(lightResolution), .lightPeriod(lightPeriod),
    .lightGain(lightGain), .lightStatusClear(lightStatusClear), .proxStatusClear(proxStatusClear));
  sensor_support_model #(.CONV_CYCLES(6)) sensor_support_model_inst (
    .sys_clk(sys_clk), .srst(srst), .oscEnable(oscEnable), .trimLoadStart(trimLoadStart),
    .lightConvStart(lightConvStart), .proxConvStart(proxConvStart), .oscReady(oscReady),
    .trimLoadDone(trimLoadDone), .lightBusy(lightBusy), .proxBusy(proxBusy));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // ends just after the taking edge so registered effects can be checked at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    ack = busAck;
    regWrite <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    ack = busAck;
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic wait_loaded();
    int i;
    for (i = 0; i < 50 && addressLoaded !== 1'b1; i++)
      @(posedge sys_clk);
    #1 chk({7'h0, addressLoaded}, 8'h01, "address load");
    chk({7'h0, trimLoadStart}, 8'h00, "loader released");
  endtask : wait_loaded
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #(50 * 4000);
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    wr(8'h15, 8'h01);
    chk({7'h0, ack}, 8'h00, "ack before load");
    chk({7'h0, oscEnable}, 8'h01, "osc started");
    wait_loaded();
    rd(8'h15, rdv);
    chk(rdv, 8'h00, "ctrl reset, early write ignored");
    chk({7'h0, ack}, 8'h01, "ack after load");
    chk({7'h0, supportPower}, 8'h00, "standby");
    rd(8'h22, rdv);
    chk(rdv, 8'h22, "res reset");
    rd(8'h23, rdv);
    chk(rdv, 8'h01, "gain reset");
    rd(8'h40, rdv);
    chk(rdv, 8'h00, "unmapped read");
    $display("test reset done");
    wr(8'h15, 8'h01);
    chk({7'h0, lightStatusClear}, 8'h01, "status cleared");
    chk({7'h0, supportPower}, 8'h01, "support on");
    chk({3'h0, lightChannels}, 8'h0B, "reduced channels");
    repeat (24) @(posedge sys_clk);
    lightTrigger <= 1'b1;
    @(posedge sys_clk);
    lightTrigger <= 1'b0;
    #1 chk({7'h0, lightConvStart}, 8'h01, "conv start");
    wr(8'h15, 8'h00);
    chk({7'h0, lightAdcOn}, 8'h01, "conversion finishes");
    repeat (8) @(posedge sys_clk);
    #1 chk({7'h0, lightAdcOn}, 8'h00, "adc standby");
    chk({7'h0, supportPower}, 8'h00, "support standby");
    chk({7'h0, lightStatusClear}, 8'h00, "no clear on disable");
    $display("test enable done");
    wr(8'h15, 8'h03);
    chk({7'h0, proxStatusClear}, 8'h01, "prox status cleared");
    wr(8'h15, 8'h06);
    chk({7'h0, supportPower}, 8'h01, "prox keeps support");
    chk({3'h0, lightChannels}, 8'h1F, "full channels");
    rd(8'h15, rdv);
    chk(rdv, 8'h06, "mode bit");
    wr(8'h15, 8'h00);
    wr(8'h22, 8'h53);
    chk({5'h0, lightResolution}, 8'h05, "resolution");
    chk({5'h0, lightPeriod}, 8'h03, "period");
    wr(8'h23, 8'h02);
    chk({6'h0, lightGain}, 8'h02, "gain 6x");
    wr(8'h23, 8'h03);
    chk({6'h0, lightGain}, 8'h02, "gain clamp");
    rd(8'h23, rdv);
    chk(rdv, 8'h03, "gain readback");
    wr(8'h23, 8'h01);
    chk({6'h0, lightGain}, 8'h01, "gain stepped down");
    $display("test config done");
    wr(8'h15, 8'h09);
    @(posedge sys_clk);
    lightIntCond <= 1'b1;
    @(posedge sys_clk);
    lightIntCond <= 1'b0;
    rd(8'h15, rdv);
    chk(rdv, 8'h08, "sleep after interrupt");
    @(posedge sys_clk);
    lightStatusRead <= 1'b1;
    @(posedge sys_clk);
    lightStatusRead <= 1'b0;
    #1 chk({7'h0, lightStatusClear}, 8'h01, "rearm clears status");
    rd(8'h15, rdv);
    chk(rdv, 8'h09, "rearm sets enable");
    wr(8'h15, 8'h12);
    chk({7'h0, proxStatusClear}, 8'h01, "prox activation clears status");
    repeat (24) @(posedge sys_clk);
    proxTrigger <= 1'b1;
    @(posedge sys_clk);
    proxTrigger <= 1'b0;
    #1 chk({7'h0, proxConvStart}, 8'h01, "prox conv start");
    @(posedge sys_clk);
    proxIntCond <= 1'b1;
    @(posedge sys_clk);
    proxIntCond <= 1'b0;
    #1 chk({7'h0, proxAdcOn}, 8'h01, "prox conversion finishes");
    repeat (8) @(posedge sys_clk);
    #1 chk({7'h0, proxAdcOn}, 8'h00, "prox adc standby");
    chk({7'h0, supportPower}, 8'h00, "support standby after sleep");
    rd(8'h15, rdv);
    chk(rdv, 8'h10, "prox sleep after interrupt");
    @(posedge sys_clk);
    proxStatusRead <= 1'b1;
    @(posedge sys_clk);
    proxStatusRead <= 1'b0;
    #1 chk({7'h0, proxStatusClear}, 8'h01, "prox rearm clears status");
    rd(8'h15, rdv);
    chk(rdv, 8'h12, "prox rearm sets enable");
    $display("test sleep done");
    @(posedge sys_clk);
    softReset <= 1'b1;
    @(posedge sys_clk);
    softReset <= 1'b0;
    #1 chk({7'h0, addressLoaded}, 8'h00, "soft reset start");
    chk({7'h0, oscEnable}, 8'h00, "start state stops oscillator");
    wr(8'h15, 8'h01);
    chk({7'h0, ack}, 8'h00, "nack after soft reset");
    wait_loaded();
    rd(8'h15, rdv);
    chk(rdv, 8'h00, "ctrl after soft reset");
    chk({7'h0, supportPower}, 8'h00, "low power standby");
    $display("test soft reset done");
    report_and_stop();
  end
endmodule : optical_sensor_mode_control_bench

// ---- sim/sensor_support_model.sv ----
// Purpose: oscillator, trim loader and converter stand-ins facing the mode controller
// Assumes: counts are short so the start-up sequence fits a brief run
// Notes: busy is a level that lasts CONV_CYCLES after each start pulse
`timescale 1ns/1ps
module sensor_support_model #(
  parameter int CONV_CYCLES = 6
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic oscEnable,
  input  wire logic trimLoadStart,
  input  wire logic lightConvStart,
  input  wire logic proxConvStart,
  output logic      oscReady,
  output logic      trimLoadDone,
  output logic      lightBusy,
  output logic      proxBusy
);
  logic [2:0] oscCnt;
  logic [2:0] loadCnt;
  int         lightCnt;
  int         proxCnt;
  // oscillator stops whenever enable drops, so a soft reset restarts it
  always_ff @(posedge sys_clk)
  begin
    oscCnt   <= (srst || !oscEnable) ? 3'h0 : (oscCnt == 3'h3 ? oscCnt : oscCnt + 3'h1);
    loadCnt  <= (srst || !trimLoadStart) ? 3'h0 : (loadCnt == 3'h4 ? loadCnt : loadCnt + 3'h1);
    lightCnt <= srst ? 0 : (lightConvStart ? CONV_CYCLES : (lightCnt > 0 ? lightCnt - 1 : 0));
    proxCnt  <= srst ? 0 : (proxConvStart ? CONV_CYCLES : (proxCnt > 0 ? proxCnt - 1 : 0));
  end
  assign oscReady     = (oscCnt == 3'h3);
  assign trimLoadDone = (loadCnt == 3'h4);
  assign lightBusy    = (lightCnt != 0);
  assign proxBusy     = (proxCnt != 0);
endmodule : sensor_support_model
